// ===== hdl/dpsc_defs.svh
// Behaviour
// - DSCP 0x36/0x37 use map register 0x035B fields
// - DSCP 0x38/0x39 use map register 0x035C fields
// - DSCP 0x3A/0x3B use map register 0x035D fields
// - DSCP 0x3C/0x3D use map register 0x035E fields
// - DSCP 0x3E/0x3F use map register 0x035F fields
// - Two 3-bit fields, reset zero, bits 7,3 zero
// - IGMP snoop enable bit 6 sends IGMP to host
// - MLD snoop enable bit 2 sends MLD to host
// - Option set: next header 43,44,50,51,60 match
// - Option clear: next header 1 or 58 match
// - Sniff bit set: source and destination match
// - Sniff bit clear: source or destination match
// - Mirror needs per-port ingress mirror setting too
// - Colour register: red 11, yellow 10, green 01
`ifndef DPSC_DEFS_SVH
`define DPSC_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DPSC_ADDR_W 16
`define DPSC_OFF_MAP_36 16'h035B
`define DPSC_OFF_MAP_38 16'h035C
`define DPSC_OFF_MAP_3A 16'h035D
`define DPSC_OFF_MAP_3C 16'h035E
`define DPSC_OFF_MAP_3E 16'h035F
`define DPSC_OFF_GLOBAL 16'h0370
`define DPSC_OFF_COLOUR 16'h0378
// ----------------------------------------
// Field layout and resets
// ----------------------------------------
`define DPSC_MAP_MASK 8'h77
`define DPSC_GLB_MASK 8'h4D
`define DPSC_COL_MASK 8'h3F
`define DPSC_COL_RESET 8'h39
`define DPSC_BIT_IGMP 6
`define DPSC_BIT_MLDOPT 3
`define DPSC_BIT_MLD 2
`define DPSC_BIT_SNIFF 0
`define DPSC_DSCP_BASE 6'h36
`define DPSC_NMAP 5
// ----------------------------------------
// IPv6 next header codes
// ----------------------------------------
`define DPSC_NH_HOP 8'h00
`define DPSC_NH_ICMP 8'h01
`define DPSC_NH_ICMP6 8'h3A
`define DPSC_NH_43 8'h2B
`define DPSC_NH_44 8'h2C
`define DPSC_NH_50 8'h32
`define DPSC_NH_51 8'h33
`define DPSC_NH_60 8'h3C
`endif

// ===== hdl/dpsc_pkg.sv
`default_nettype none
package dpsc_pkg;
  typedef logic [7:0] dpsc_byte_t;
  typedef logic [2:0] dpsc_prio_t;
  typedef enum logic [1:0] {DPSC_IP_NONE = 2'h0, DPSC_IP_V4 = 2'h1, DPSC_IP_V6 = 2'h3}
    dpsc_ipver_t;
endpackage : dpsc_pkg
`default_nettype wire

// ===== hdl/dpsc_cfg_if.sv
`default_nettype none
// Configuration fields handed from the register file to the classifier
interface dpsc_cfg_if;
  logic [7:0] map [0:4];
  logic igmp_en;
  logic mld_en;
  logic mld_opt;
  logic sniff_and;
  modport regs (output map, output igmp_en, output mld_en, output mld_opt, output sniff_and);
  modport cls (input map, input igmp_en, input mld_en, input mld_opt, input sniff_and);
endinterface : dpsc_cfg_if
`default_nettype wire

// ===== hdl/dpsc_regs.sv
`include "dpsc_defs.svh"
`default_nettype none
module dpsc_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Colour values
  output logic [5:0] colour,
  // Configuration out
  dpsc_cfg_if.regs cfg
);
  logic [7:0] map_q [0:4];
  logic [7:0] map_d [0:4];
  logic [7:0] glb_q, glb_d, col_q, col_d, rd_q, rd_d;

  // ----------------------------------------
  // Decode and next state
  // ----------------------------------------
  // Masks keep reserved bits at zero so reads need no extra gating
  always_comb
  begin
    for (int i = 0; i < `DPSC_NMAP; i++)
    begin
      map_d[i] = map_q[i];
    end
    glb_d = glb_q;
    col_d = col_q;
    rd_d = 8'h00;
    if (wr)
    begin
      case (addr)
        `DPSC_OFF_MAP_36: map_d[0] = wdata & `DPSC_MAP_MASK;
        `DPSC_OFF_MAP_38: map_d[1] = wdata & `DPSC_MAP_MASK;
        `DPSC_OFF_MAP_3A: map_d[2] = wdata & `DPSC_MAP_MASK;
        `DPSC_OFF_MAP_3C: map_d[3] = wdata & `DPSC_MAP_MASK;
        `DPSC_OFF_MAP_3E: map_d[4] = wdata & `DPSC_MAP_MASK;
        `DPSC_OFF_GLOBAL: glb_d = wdata & `DPSC_GLB_MASK;
        `DPSC_OFF_COLOUR: col_d = wdata & `DPSC_COL_MASK;
        default: ;
      endcase
    end
    if (rd)
    begin
      case (addr)
        `DPSC_OFF_MAP_36: rd_d = map_q[0];
        `DPSC_OFF_MAP_38: rd_d = map_q[1];
        `DPSC_OFF_MAP_3A: rd_d = map_q[2];
        `DPSC_OFF_MAP_3C: rd_d = map_q[3];
        `DPSC_OFF_MAP_3E: rd_d = map_q[4];
        `DPSC_OFF_GLOBAL: rd_d = glb_q;
        `DPSC_OFF_COLOUR: rd_d = col_q;
        default: rd_d = 8'h00;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `DPSC_NMAP; i++)
      begin
        map_q[i] <= 8'h00;
      end
      glb_q <= 8'h00;
      col_q <= `DPSC_COL_RESET;
      rd_q <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < `DPSC_NMAP; i++)
      begin
        map_q[i] <= map_d[i];
      end
      glb_q <= glb_d;
      col_q <= col_d;
      rd_q <= rd_d;
    end
  end

  // Outputs
  assign rdata = rd_q;
  assign colour = col_q[5:0];
  assign cfg.map = map_q;
  assign cfg.igmp_en = glb_q[`DPSC_BIT_IGMP];
  assign cfg.mld_en = glb_q[`DPSC_BIT_MLD];
  assign cfg.mld_opt = glb_q[`DPSC_BIT_MLDOPT];
  assign cfg.sniff_and = glb_q[`DPSC_BIT_SNIFF];
endmodule : dpsc_regs
`default_nettype wire

// ===== hdl/dpsc_classify.sv
`include "dpsc_defs.svh"
`default_nettype none
module dpsc_classify (
  // Frame descriptor
  input wire dpsc_pkg::dpsc_ipver_t ipver,
  input wire logic [7:0] tos,
  input wire logic is_igmp,
  input wire logic [7:0] next_hdr,
  input wire logic [7:0] hop_next_hdr,
  input wire logic src_match,
  input wire logic dst_match,
  input wire logic port_mirror_en,
  // Configuration
  dpsc_cfg_if.cls cfg,
  // Results
  output logic prio_hit,
  output logic [2:0] prio,
  output logic to_host,
  output logic mirror
);
  logic [5:0] dscp;
  logic [5:0] idx;
  logic [7:0] sel;
  logic nh_ok;
  logic hop_ok;
  logic is_v6;

  // Next header match; one function serves both header levels
  function automatic logic dpsc_nh_match(input logic [7:0] nh, input logic opt);
    if (opt)
      dpsc_nh_match = (nh == `DPSC_NH_43) || (nh == `DPSC_NH_44) || (nh == `DPSC_NH_50)
                      || (nh == `DPSC_NH_51) || (nh == `DPSC_NH_60);
    else
      dpsc_nh_match = (nh == `DPSC_NH_ICMP) || (nh == `DPSC_NH_ICMP6);
  endfunction : dpsc_nh_match

  // ----------------------------------------
  // Priority lookup
  // ----------------------------------------
  assign dscp = tos[7:2];
  assign idx = dscp - `DPSC_DSCP_BASE;
  always_comb
  begin
    prio_hit = (ipver != dpsc_pkg::DPSC_IP_NONE) && (dscp >= `DPSC_DSCP_BASE);
    sel = prio_hit ? cfg.map[idx[3:1]] : 8'h00;
    prio = idx[0] ? sel[6:4] : sel[2:0];
  end

  // ----------------------------------------
  // Snooping and sniffing
  // ----------------------------------------
  assign is_v6 = (ipver == dpsc_pkg::DPSC_IP_V6);
  assign nh_ok = dpsc_nh_match(next_hdr, cfg.mld_opt);
  assign hop_ok = (next_hdr == `DPSC_NH_HOP) && dpsc_nh_match(hop_next_hdr, cfg.mld_opt);
  always_comb
  begin
    to_host = (cfg.igmp_en && (ipver == dpsc_pkg::DPSC_IP_V4) && is_igmp)
              || (cfg.mld_en && is_v6 && (nh_ok || hop_ok));
    // Global select alone never mirrors; the port setting gates it
    mirror = port_mirror_en && (cfg.sniff_and ? (src_match && dst_match)
                                              : (src_match || dst_match));
  end
endmodule : dpsc_classify
`default_nettype wire

// ===== hdl/dpsc_top.sv
`include "dpsc_defs.svh"
`default_nettype none
module dpsc_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Frame descriptor, same clock, valid with frame_valid
  input wire logic frame_valid,
  input wire dpsc_pkg::dpsc_ipver_t ipver,
  input wire logic [7:0] tos,
  input wire logic is_igmp,
  input wire logic [7:0] next_hdr,
  input wire logic [7:0] hop_next_hdr,
  input wire logic src_match,
  input wire logic dst_match,
  input wire logic port_mirror_en,
  // Results, one cycle after frame_valid; colour comes straight from the register file
  output logic res_valid,
  output logic prio_hit,
  output logic [2:0] prio,
  output logic to_host,
  output logic mirror,
  output logic [5:0] colour
);
  dpsc_cfg_if cfg_bus ();
  logic [7:0] rdata_w;
  logic [5:0] colour_w;
  logic hit_w, host_w, mir_w;
  logic [2:0] prio_w;
  logic [5:0] res_d, res_q;
  logic val_q;

  // Register file; read data already registered inside
  dpsc_regs u_regs (
    .clock(clock),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata_w),
    .colour(colour_w),
    .cfg(cfg_bus.regs)
  );

  // Combinational classifier
  dpsc_classify u_cls (
    .ipver(ipver),
    .tos(tos),
    .is_igmp(is_igmp),
    .next_hdr(next_hdr),
    .hop_next_hdr(hop_next_hdr),
    .src_match(src_match),
    .dst_match(dst_match),
    .port_mirror_en(port_mirror_en),
    .cfg(cfg_bus.cls),
    .prio_hit(hit_w),
    .prio(prio_w),
    .to_host(host_w),
    .mirror(mir_w)
  );

  // Results are zero outside a valid frame so stale decisions never leak
  always_comb
  begin
    res_d = frame_valid ? {hit_w, prio_w, host_w, mir_w} : 6'h00;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      res_q <= 6'h00;
      val_q <= 1'b0;
    end
    else
    begin
      res_q <= res_d;
      val_q <= frame_valid;
    end
  end

  assign rdata = rdata_w;
  assign colour = colour_w;
  assign res_valid = val_q;
  assign prio_hit = res_q[5];
  assign prio = res_q[4:2];
  assign to_host = res_q[1];
  assign mirror = res_q[0];
endmodule : dpsc_top
`default_nettype wire

// ===== sim/dpsc_top_properties.sv
`default_nettype none
module dpsc_top_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Frame and results
  input wire logic frame_valid,
  input wire dpsc_pkg::dpsc_ipver_t ipver,
  input wire logic [7:0] tos,
  input wire logic is_igmp,
  input wire logic src_match,
  input wire logic dst_match,
  input wire logic port_mirror_en,
  input wire logic res_valid,
  input wire logic prio_hit,
  input wire logic [2:0] prio,
  input wire logic to_host,
  input wire logic mirror,
  input wire logic [5:0] colour
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Implication forms, so values held during reset never reach the check
  AST_RES_VALID: assert property (frame_valid |=> res_valid) else $error("no result");
  AST_RES_IDLE: assert property (
    !frame_valid |=> !(res_valid | prio_hit | to_host | mirror))
    else $error("result without frame");
  AST_LOW_DSCP: assert property (
    frame_valid && tos[7:2] < 6'h36 |=> !prio_hit && prio == 3'h0)
    else $error("low code point hit");
  AST_NO_IP: assert property (
    frame_valid && ipver == dpsc_pkg::DPSC_IP_NONE |=> !prio_hit && !to_host)
    else $error("non-IP frame classified");
  AST_MIRROR_PORT: assert property (frame_valid && !port_mirror_en |=> !mirror)
    else $error("mirror without port setting");
  AST_SNIFF_NONE: assert property (frame_valid && !src_match && !dst_match |=> !mirror)
    else $error("mirror without match");
  AST_SNIFF_BOTH: assert property (
    frame_valid && src_match && dst_match && port_mirror_en |=> mirror)
    else $error("both matched, no mirror");
  AST_IGMP_ONLY: assert property (
    frame_valid && ipver == dpsc_pkg::DPSC_IP_V4 && !is_igmp |=> !to_host)
    else $error("non-IGMP sent to host");
  AST_MAP_RSVD: assert property (
    rd && addr >= 16'h035B && addr <= 16'h035F |=> rdata[7] == 1'b0 && rdata[3] == 1'b0)
    else $error("reserved bit set");
  AST_COLOUR_WR: assert property (wr && addr == 16'h0378 |=> colour == $past(wdata[5:0]))
    else $error("colour not updated");
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00) else $error("rdata held");
  // Main scenarios reached
  COV_PRIO: cover property (res_valid && prio_hit);
  COV_HOST: cover property (res_valid && to_host);
  COV_MIRROR: cover property (res_valid && mirror);
endmodule : dpsc_top_properties
bind dpsc_top dpsc_top_properties i_props (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
  .frame_valid, .ipver, .tos, .is_igmp, .src_match, .dst_match, .port_mirror_en, .res_valid,
  .prio_hit, .prio, .to_host, .mirror, .colour);
`default_nettype wire

// ===== sim/dpsc_top_tb_top.sv
`default_nettype none
module dpsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam dpsc_pkg::dpsc_ipver_t v4 = dpsc_pkg::DPSC_IP_V4;
  localparam dpsc_pkg::dpsc_ipver_t v6 = dpsc_pkg::DPSC_IP_V6;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, tos = 8'h00, next_hdr = 8'h00, hop_next_hdr = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0, frame_valid = 1'b0, is_igmp = 1'b0, src_match = 1'b0;
  logic dst_match = 1'b0, port_mirror_en = 1'b0;
  dpsc_pkg::dpsc_ipver_t ipver = dpsc_pkg::DPSC_IP_NONE;
  logic res_valid, prio_hit, to_host, mirror;
  logic [2:0] prio;
  logic [5:0] colour;
  int mismatches = 0, n_checks = 0, cyc = 0;
  dpsc_top i_dut (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .frame_valid, .ipver, .tos,
    .is_igmp, .next_hdr, .hop_next_hdr, .src_match, .dst_match, .port_mirror_en, .res_valid,
    .prio_hit, .prio, .to_host, .mirror, .colour);
  // ----------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  // A hang ends the run as a failure; a full pass needs about two hundred cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rchk
  // Result word: valid, hit, host, mirror, 0, priority
  task automatic fr(input dpsc_pkg::dpsc_ipver_t v, input logic [7:0] t, input logic ig,
    input logic [7:0] n, input logic [7:0] h, input logic [2:0] sdp, input logic [7:0] e);
    @(posedge clock);
    frame_valid <= 1'b1;
    ipver <= v;
    tos <= t;
    is_igmp <= ig;
    next_hdr <= n;
    hop_next_hdr <= h;
    {port_mirror_en, src_match, dst_match} <= sdp;
    @(posedge clock);
    frame_valid <= 1'b0;
    #1;
    chk({res_valid, prio_hit, to_host, mirror, 1'b0, prio}, e);
  endtask : fr
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 5; i++)
      rchk(16'h035B + 16'(i), 8'h00);
    rchk(16'h0370, 8'h00);
    rchk(16'h0378, 8'h39);
    chk({2'b00, colour}, 8'h39);
    $display("test reset done");
  endtask : t_reset
  // Reserved bits written as ones must be dropped
  task automatic t_maps;
    logic [7:0] e;
    for (int i = 0; i < 5; i++)
      wreg(16'h035B + 16'(i), {1'b1, 3'(i + 1), 1'b1, 3'(6 - i)});
    wreg(16'h0360, 8'hFF);
    for (int i = 0; i < 5; i++)
    begin
      rchk(16'h035B + 16'(i), {4'(i + 1), 4'(6 - i)});
      // Even code point takes the low field, odd the high field
      e = {5'h18, 3'(6 - i)};
      fr(v4, {6'h36 + 6'(2 * i), 2'b11}, 1'b0, 8'h00, 8'h00, 3'h0, e);
      e = {5'h18, 3'(i + 1)};
      fr(v6, {6'h37 + 6'(2 * i), 2'b00}, 1'b0, 8'h00, 8'h00, 3'h0, e);
    end
    rchk(16'h0360, 8'h00);
    fr(v4, 8'hD4, 1'b0, 8'h00, 8'h00, 3'h0, 8'h80);
    $display("test maps done");
  endtask : t_maps
  task automatic t_snoop;
    logic [7:0] nh [8] = '{8'h01, 8'h3A, 8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C, 8'h11};
    logic m;
    wreg(16'h0370, 8'hFF);
    rchk(16'h0370, 8'h4D);
    fr(v4, 8'h00, 1'b1, 8'h00, 8'h00, 3'h0, 8'hA0);
    for (int o = 0; o < 2; o++)
    begin
      wreg(16'h0370, o ? 8'h0C : 8'h04);
      for (int k = 0; k < 8; k++)
      begin
        m = o ? (k > 1 && k < 7) : (k < 2);
        fr(v6, 8'h00, 1'b0, nh[k], 8'h00, 3'h0, {2'b10, m, 5'h00});
        fr(v6, 8'h00, 1'b0, 8'h00, nh[k], 3'h0, {2'b10, m, 5'h00});
      end
    end
    fr(v4, 8'h00, 1'b1, 8'h00, 8'h00, 3'h0, 8'h80);
    wreg(16'h0370, 8'h40);
    fr(v6, 8'h00, 1'b0, 8'h3A, 8'h00, 3'h0, 8'h80);
    $display("test snoop done");
  endtask : t_snoop
  task automatic t_sniff;
    logic m;
    for (int s = 0; s < 2; s++)
    begin
      wreg(16'h0370, 8'(s));
      for (int c = 0; c < 8; c++)
      begin
        m = c[2] & (s ? c[1] & c[0] : c[1] | c[0]);
        fr(v4, 8'h00, 1'b0, 8'h00, 8'h00, 3'(c), {3'b100, m, 4'h0});
      end
    end
    wreg(16'h0378, 8'hFF);
    rchk(16'h0378, 8'h3F);
    chk({2'b00, colour}, 8'h3F);
    $display("test sniff and colour done");
  endtask : t_sniff
  // Main sequence, with a second reset after the last scenario, then the reset check again
  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_maps();
    t_snoop();
    t_sniff();
    @(posedge clock);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    give_verdict();
  end
endmodule : dpsc_top_tb_top
`default_nettype wire
